// *** bench/pac_alarm_top_tb_top.sv ***
`timescale 1ns/1ps
`include "pac_map.svh"
module pac_alarm_top_tb_top;
  typedef struct packed {
    logic rd;
    logic pins;
    logic irq;
    logic alm;
    logic [1:0] resp;
    logic [31:0] m;
    logic [31:0] d;
  } pac_note_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic signed [23:0] fb = '0, cmd = '0, mv = '0;
  logic key = 1'h0, rel = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic awr, wrd, bv, arr, rv, alm, irq, term, inr;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  pac_note_t q[$];
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  pac_alarm_top DUT (.i_clk_sys(clk), .i_sys_rst(rst), .i_feedback_value(fb), .i_command_value(cmd),
    .i_manipulated_value(mv), .i_reset_key(key), .i_reset_terminal(term), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
    .o_s_axi_bresp(br), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr),
    .o_process_alarm_out(alm), .o_irq(irq));
  pac_terminal_model far_end (.i_clk_sys(clk), .i_alarm(alm), .i_release_req(rel),
    .o_reset_terminal(term), .o_in_range(inr));

  task automatic wrap_up();
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [31:0] lvl(input int v);
    return {11'h000, v[20:0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = `PAC_RESP_OKAY);
    q.push_back('{1'h0, 1'h0, 1'h0, 1'h0, resp, 32'h0, 32'h0});
    @(posedge clk);
    awv <= 1'h1;
    wv <= 1'h1;
    awa <= a;
    wd <= d;
    bre <= 1'h1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wrd) wv <= 1'h0;
    end while (!(bv && bre));
    bre <= 1'h0;
  endtask
  task automatic rdn(input logic [7:0] a, input pac_note_t n);
    q.push_back(n);
    @(posedge clk);
    arv <= 1'h1;
    ara <= a;
    rre <= 1'h1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'h0;
    end while (!(rv && rre));
    rre <= 1'h0;
  endtask
  task automatic rdv(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                     input logic [1:0] resp = `PAC_RESP_OKAY);
    rdn(a, '{1'h1, 1'h0, 1'h0, 1'h0, resp, m, d & m});
  endtask
  // status read that also looks at both output pins
  task automatic st(input logic a, input logic r, input logic i);
    rdn(`PAC_ADDR_STATUS, '{1'h1, 1'h1, i, a, `PAC_RESP_OKAY, 32'h3, {30'h0, r, a}});
  endtask
  task automatic set_q(input int f, input int c, input int m);
    fb <= 24'(f);
    cmd <= 24'(c);
    mv <= 24'(m);
    repeat (4) @(posedge clk);
  endtask
  task automatic do_reset();
    rst <= 1'h1;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
  endtask

  // monitor: every bus answer retires the oldest note
  always @(posedge clk) begin
    pac_note_t n;
    pac_note_t g;
    if ((bv && bre) || (rv && rre)) begin
      n = q.pop_front();
      g = n;
      g.rd = rv && rre;
      g.irq = n.pins ? irq : n.irq;
      g.alm = n.pins ? alm : n.alm;
      g.resp = g.rd ? rr : br;
      g.d = g.rd ? (rdat & n.m) : n.d;
      check_count++;
      if (g !== n) begin
        fails++;
        $display("BAD t=%0t got %h exp %h", $time, g, n);
      end
      if (n.pins) begin
        check_count++;
        if (inr !== !n.alm) begin
          fails++;
          $display("BAD t=%0t got %h exp %h", $time, inr, !n.alm);
        end
      end
    end
  end
  // hang guard, far above the length of the sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    int v, r, c;
    logic e;
    void'($urandom(32'hBA1F));
    do_reset();
    rdv(`PAC_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    rdv(`PAC_ADDR_UPPER, 32'hFFFFFFFF, `PAC_LVL_RST);
    rdv(`PAC_ADDR_LOWER, 32'hFFFFFFFF, `PAC_LVL_RST);
    rdv(`PAC_ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    rdv(8'h18, 32'hFFFFFFFF, 32'h0, `PAC_RESP_SLVERR);
    wr(8'h20, 32'h1, `PAC_RESP_SLVERR);
    set_q(99999, 99999, 99999);
    st(1'h0, 1'h0, 1'h0);
    for (int t = 0; t < 16; t++) begin
      wr(`PAC_ADDR_CTRL, 32'(t));
      rdv(`PAC_ADDR_CTRL, 32'h1F, 32'(t));
    end
    // span ends accepted, one step past refused and flagged
    wr(`PAC_ADDR_LOWER, lvl(-99900));
    rdv(`PAC_ADDR_LOWER, 32'hFFFFFFFF, lvl(-99900));
    wr(`PAC_ADDR_UPPER, lvl(999000));
    wr(`PAC_ADDR_UPPER, lvl(999001));
    rdv(`PAC_ADDR_UPPER, 32'hFFFFFFFF, lvl(999000));
    rdv(`PAC_ADDR_IRQ_STS, 32'h7, 32'h4);
    // each quantity against an asymmetric window, other inputs parked in alarm
    wr(`PAC_ADDR_UPPER, lvl(2000));
    for (int t = 0; t < 16; t += 4) begin
      wr(`PAC_ADDR_CTRL, 32'(t));
      wr(`PAC_ADDR_LOWER, lvl(t == 4 ? 1000 : -1000));
      for (int k = 0; k < 5; k++) begin
        r = $urandom_range(2999, 0);
        c = $urandom_range(3000, 0) - 1500;
        v = k == 0 ? -1001 - r % 500 : k == 1 ? -1000 : k == 2 ? 2000 : k == 3 ? 2001 + r % 500 : r - 1000;
        e = v < -1000 || v > 2000;
        set_q(t == 0 ? v : t == 4 ? c + v : 5000, t == 8 ? v : t == 4 ? c : 5000, t == 12 ? v : 5000);
        st(e, e, 1'h0);
      end
    end
    // symmetric deviation window
    wr(`PAC_ADDR_LOWER, lvl(1000));
    wr(`PAC_ADDR_CTRL, 32'h14);
    set_q(1001, 0, 0);
    st(1'h1, 1'h1, 1'h0);
    set_q(1000, 0, 0);
    st(1'h0, 1'h0, 1'h0);
    // upper side off, lower side still live
    wr(`PAC_ADDR_CTRL, 32'h0);
    wr(`PAC_ADDR_UPPER, `PAC_LVL_RST);
    set_q(900000, 0, 0);
    st(1'h0, 1'h0, 1'h0);
    set_q(999, 0, 0);
    st(1'h1, 1'h1, 1'h0);
    // interrupt: rise enabled, fall masked
    set_q(5000, 0, 0);
    rdv(`PAC_ADDR_IRQ_STS, 32'h0, 32'h0);
    wr(`PAC_ADDR_IRQ_MASK, 32'h1);
    set_q(0, 0, 0);
    st(1'h1, 1'h1, 1'h1);
    rdv(`PAC_ADDR_IRQ_STS, 32'h7, 32'h1);
    st(1'h1, 1'h1, 1'h0);
    set_q(5000, 0, 0);
    st(1'h0, 1'h0, 1'h0);
    rdv(`PAC_ADDR_IRQ_STS, 32'h7, 32'h2);
    wr(`PAC_ADDR_IRQ_MASK, 32'h0);
    // latch, released by terminal, key and register in turn
    wr(`PAC_ADDR_CTRL, 32'h2);
    for (int p = 0; p < 3; p++) begin
      set_q(0, 0, 0);
      st(1'h1, 1'h1, 1'h0);
      set_q(5000, 0, 0);
      st(1'h1, 1'h0, 1'h0);
      if (p == 0) begin
        rel <= 1'h1;
        @(posedge clk);
        rel <= 1'h0;
      end else if (p == 1) begin
        key <= 1'h1;
        repeat (2) @(posedge clk);
        key <= 1'h0;
      end else wr(`PAC_ADDR_CTRL, 32'h102);
      repeat (8) @(posedge clk);
      st(1'h0, 1'h0, 1'h0);
    end
    // hold after a fresh power-on: kept off inside the range, then out and in arms it
    do_reset();
    set_q(0, 0, 0);
    wr(`PAC_ADDR_LOWER, lvl(1000));
    wr(`PAC_ADDR_CTRL, 32'h1);
    st(1'h0, 1'h1, 1'h0);
    rdv(`PAC_ADDR_STATUS, 32'h4, 32'h4);
    set_q(5000, 0, 0);
    st(1'h0, 1'h0, 1'h0);
    set_q(0, 0, 0);
    st(1'h1, 1'h1, 1'h0);
    wrap_up();
  end
endmodule

// *** bench/pac_terminal_model.sv ***
`timescale 1ns/1ps
// far-side equipment: watches the alarm pin and pulses the reset terminal on request
module pac_terminal_model (
  input wire logic i_clk_sys,
  input wire logic i_alarm,
  input wire logic i_release_req,
  output logic o_reset_terminal,
  output logic o_in_range
);
  logic [2:0] hold_cnt = 3'h0;
  // a pulse of a few cycles, long enough for the pin synchroniser
  always @(posedge i_clk_sys) begin
    if (i_release_req) hold_cnt <= 3'h4;
    else if (hold_cnt != 3'h0) hold_cnt <= hold_cnt - 3'h1;
  end
  assign o_reset_terminal = (hold_cnt != 3'h0);
  // negative-logic view used for an in-range indication
  assign o_in_range = ~i_alarm;
endmodule

// *** rtl/pac_alarm_if.sv ***
`timescale 1ns/1ps
interface pac_alarm_if #(parameter int VW = 24);
  logic [3:0] type_code;
  logic sym;
  logic signed [VW-1:0] fb;
  logic signed [VW-1:0] cmd;
  logic signed [VW-1:0] mv;
  logic signed [VW-1:0] upper;
  logic signed [VW-1:0] lower;
  logic upper_off;
  logic lower_off;
  logic in_range;
  logic release_cmd;
  logic alarm;
  logic hold_pending;
  modport cfg(output type_code, sym, fb, cmd, mv, upper, lower, upper_off, lower_off, release_cmd,
              input in_range, alarm, hold_pending);
  modport cmp(input type_code, sym, fb, cmd, mv, upper, lower, upper_off, lower_off,
              output in_range);
  modport hl(input type_code, in_range, release_cmd, output alarm, hold_pending);
endinterface

// *** rtl/pac_alarm_top.sv ***
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pac_map.svh"
module pac_alarm_top
  import pac_pkg::*;
#(
  parameter int AW = 8,
  parameter int VW = 24
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic signed [VW-1:0] i_feedback_value,
  input wire logic signed [VW-1:0] i_command_value,
  input wire logic signed [VW-1:0] i_manipulated_value,
  input wire logic i_reset_key,
  input wire logic i_reset_terminal,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [AW-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_process_alarm_out,
  output logic o_irq
);
  pac_alarm_if #(.VW(VW)) alm();

  // configuration and state
  logic [3:0] type_code;
  logic sym;
  logic upper_off;
  logic [`PAC_LVL_MSB:0] upper_val;
  logic lower_off;
  logic [`PAC_LVL_MSB:0] lower_val;
  logic [`PAC_IRQ_W-1:0] irq_sts;
  logic [`PAC_IRQ_W-1:0] irq_mask;

  // write and read channel state
  logic aw_held;
  logic w_held;
  logic [AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;
  logic ar_take;

  // merges byte lanes of a write into the old word
  function automatic logic [31:0] pac_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // level word is ok when off or inside the settable span
  function automatic logic pac_level_ok(input logic [31:0] w);
    logic signed [`PAC_LVL_MSB:0] v;
    v = w[`PAC_LVL_MSB:0];
    return w[`PAC_LVL_OFF_BIT] ||
           (v >= $signed(`PAC_LVL_MIN) && v <= $signed(`PAC_LVL_MAX));
  endfunction

  // readable words; reserved bits read as zero
  logic [31:0] ctrl_word;
  logic [31:0] upper_word;
  logic [31:0] lower_word;
  logic [31:0] status_word;
  assign ctrl_word = {{(31-`PAC_CTRL_SYM_BIT){1'b0}}, sym, type_code};
  assign upper_word = {upper_off, {(`PAC_LVL_OFF_BIT-`PAC_LVL_W){1'b0}}, upper_val};
  assign lower_word = {lower_off, {(`PAC_LVL_OFF_BIT-`PAC_LVL_W){1'b0}}, lower_val};
  assign status_word = {29'h0, alm.hold_pending, alm.in_range, o_process_alarm_out};

  // write address decode
  logic wr_ctrl;
  logic wr_upper;
  logic wr_lower;
  logic wr_mask;
  logic wr_hit;
  logic [31:0] m_ctrl;
  logic [31:0] m_upper;
  logic [31:0] m_lower;
  logic [31:0] m_mask;
  logic upper_ok;
  logic lower_ok;
  logic sw_release;
  assign do_write = aw_held & w_held & !o_s_axi_bvalid;
  assign wr_ctrl = do_write && (aw_addr == `PAC_ADDR_CTRL);
  assign wr_upper = do_write && (aw_addr == `PAC_ADDR_UPPER);
  assign wr_lower = do_write && (aw_addr == `PAC_ADDR_LOWER);
  assign wr_mask = do_write && (aw_addr == `PAC_ADDR_IRQ_MASK);
  assign wr_hit = wr_ctrl | wr_upper | wr_lower | wr_mask;
  assign m_ctrl = pac_merge(ctrl_word, w_data, w_strb);
  assign m_upper = pac_merge(upper_word, w_data, w_strb);
  assign m_lower = pac_merge(lower_word, w_data, w_strb);
  assign m_mask = pac_merge({{(32-`PAC_IRQ_W){1'b0}}, irq_mask}, w_data, w_strb);
  assign upper_ok = pac_level_ok(m_upper);
  assign lower_ok = pac_level_ok(m_lower);
  assign sw_release = wr_ctrl & m_ctrl[`PAC_CTRL_RST_BIT];

  // channel handshakes; a channel reopens only once its word is used
  assign next_aw_held = aw_held ? !do_write : (i_s_axi_awvalid & o_s_axi_awready);
  assign next_w_held = w_held ? !do_write : (i_s_axi_wvalid & o_s_axi_wready);
  assign next_bvalid = o_s_axi_bvalid ? !i_s_axi_bready : do_write;
  assign ar_take = i_s_axi_arvalid & o_s_axi_arready;
  assign next_rvalid = o_s_axi_rvalid ? !i_s_axi_rready : ar_take;

  // read address decode
  logic rd_hit;
  logic rd_irq;
  logic [31:0] rd_data;
  assign rd_irq = (i_s_axi_araddr == `PAC_ADDR_IRQ_STS);
  assign rd_hit = rd_irq || (i_s_axi_araddr == `PAC_ADDR_CTRL) || (i_s_axi_araddr == `PAC_ADDR_UPPER) ||
                  (i_s_axi_araddr == `PAC_ADDR_LOWER) || (i_s_axi_araddr == `PAC_ADDR_STATUS) ||
                  (i_s_axi_araddr == `PAC_ADDR_IRQ_MASK);
  assign rd_data = (i_s_axi_araddr == `PAC_ADDR_CTRL) ? ctrl_word :
                   (i_s_axi_araddr == `PAC_ADDR_UPPER) ? upper_word :
                   (i_s_axi_araddr == `PAC_ADDR_LOWER) ? lower_word :
                   (i_s_axi_araddr == `PAC_ADDR_STATUS) ? status_word :
                   rd_irq ? {{(32-`PAC_IRQ_W){1'b0}}, irq_sts} :
                   (i_s_axi_araddr == `PAC_ADDR_IRQ_MASK) ? {{(32-`PAC_IRQ_W){1'b0}}, irq_mask} :
                   32'h00000000;

  // bus channel flops
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `PAC_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (i_s_axi_awvalid & o_s_axi_awready) begin
        aw_addr <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid & o_s_axi_wready) begin
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      o_s_axi_awready <= !next_aw_held & !next_bvalid;
      o_s_axi_wready <= !next_w_held & !next_bvalid;
      o_s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        o_s_axi_bresp <= wr_hit ? `PAC_RESP_OKAY : `PAC_RESP_SLVERR;
      end
    end
  end

  // read channel; one read in flight, data frozen until taken
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `PAC_RESP_OKAY;
    end else begin
      o_s_axi_arready <= !next_rvalid;
      o_s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        o_s_axi_rdata <= rd_data;
        o_s_axi_rresp <= rd_hit ? `PAC_RESP_OKAY : `PAC_RESP_SLVERR;
      end
    end
  end

  // settings; an out-of-span level write is dropped and flagged
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      type_code <= 4'h0;
      sym <= 1'b0;
      upper_off <= 1'(`PAC_LVL_RST >> `PAC_LVL_OFF_BIT);
      upper_val <= '0;
      lower_off <= 1'(`PAC_LVL_RST >> `PAC_LVL_OFF_BIT);
      lower_val <= '0;
      irq_mask <= '0;
    end else begin
      if (wr_ctrl) begin
        type_code <= m_ctrl[`PAC_CTRL_TYPE_MSB:`PAC_CTRL_TYPE_LSB];
        sym <= m_ctrl[`PAC_CTRL_SYM_BIT];
      end
      if (wr_upper && upper_ok) begin
        upper_off <= m_upper[`PAC_LVL_OFF_BIT];
        upper_val <= m_upper[`PAC_LVL_MSB:0];
      end
      if (wr_lower && lower_ok) begin
        lower_off <= m_lower[`PAC_LVL_OFF_BIT];
        lower_val <= m_lower[`PAC_LVL_MSB:0];
      end
      if (wr_mask) begin
        irq_mask <= m_mask[`PAC_IRQ_W-1:0];
      end
    end
  end

  // reset key and reset terminal: three-stage sync, counted once stages two and three agree
  logic [1:0] pin_raw;
  logic [1:0] pin_pulse;
  assign pin_raw = {i_reset_terminal, i_reset_key};
  for (genvar g = 0; g < 2; g++) begin : g_rst_sync
    logic s1;
    logic s2;
    logic s3;
    logic stab;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        stab <= 1'b0;
      end else begin
        s1 <= pin_raw[g];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          stab <= s3;
        end
      end
    end
    assign pin_pulse[g] = (s2 == s3) & s3 & !stab;
  end

  // hand settings and values to the comparator and the hold/latch stage
  assign alm.type_code = type_code;
  assign alm.sym = sym;
  assign alm.fb = i_feedback_value;
  assign alm.cmd = i_command_value;
  assign alm.mv = i_manipulated_value;
  assign alm.upper = VW'($signed(upper_val));
  assign alm.lower = VW'($signed(lower_val));
  assign alm.upper_off = upper_off;
  assign alm.lower_off = lower_off;
  assign alm.release_cmd = (|pin_pulse) | sw_release;

  pac_compare #(.VW(VW)) u_cmp (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .a(alm.cmp)
  );

  pac_hold_latch u_hl (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .a(alm.hl)
  );

  // sticky events; a read clears, but an event in that cycle survives
  logic [`PAC_IRQ_W-1:0] irq_ev;
  logic [`PAC_IRQ_W-1:0] irq_clr;
  logic [`PAC_IRQ_W-1:0] next_irq_sts;
  logic [`PAC_IRQ_W-1:0] next_irq_mask;
  assign irq_ev[`PAC_IRQ_RISE_BIT] = alm.alarm & !o_process_alarm_out;
  assign irq_ev[`PAC_IRQ_FALL_BIT] = !alm.alarm & o_process_alarm_out;
  assign irq_ev[`PAC_IRQ_REJ_BIT] = (wr_upper & !upper_ok) | (wr_lower & !lower_ok);
  assign irq_clr = (ar_take && rd_irq) ? {`PAC_IRQ_W{1'b1}} : {`PAC_IRQ_W{1'b0}};
  assign next_irq_sts = (irq_sts & ~irq_clr) | irq_ev;
  assign next_irq_mask = wr_mask ? m_mask[`PAC_IRQ_W-1:0] : irq_mask;

  // outputs registered so the terminal never sees decode glitches
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_sts <= '0;
      o_irq <= 1'b0;
      o_process_alarm_out <= 1'b0;
    end else begin
      irq_sts <= next_irq_sts;
      o_irq <= |(next_irq_sts & next_irq_mask);
      o_process_alarm_out <= alm.alarm;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_write_done;
    do_write ##1 (o_s_axi_bvalid && !do_write);
  endsequence

  a_write_answer: assert property (do_write |-> s_write_done)
    else $error("write not answered next cycle");
  a_bresp_holds: assert property ((o_s_axi_bvalid && !i_s_axi_bready) |=>
    (o_s_axi_bvalid && $stable(o_s_axi_bresp)))
    else $error("write answer dropped before taken");
  a_rdata_holds: assert property ((o_s_axi_rvalid && !i_s_axi_rready) |=>
    (o_s_axi_rvalid && $stable(o_s_axi_rdata)))
    else $error("read answer changed before taken");
  a_level_reject: assert property ((wr_upper && !upper_ok) |=> ($stable(upper_val) && $stable(upper_off)))
    else $error("out-of-span upper level stored");
  a_lower_reject: assert property ((wr_lower && !lower_ok) |=> ($stable(lower_val) && $stable(lower_off)))
    else $error("out-of-span lower level stored");
  a_irq_level: assert property (o_irq == |(irq_sts & irq_mask))
    else $error("interrupt line disagrees with masked status");
  a_out_follows: assert property (alm.alarm |=> o_process_alarm_out)
    else $error("alarm output did not follow");
  a_release_path: assert property ((sw_release && alm.alarm && !alm.in_range) |=>
    ##1 !o_process_alarm_out)
    else $error("software reset did not release latch");
endmodule

// *** rtl/pac_compare.sv ***
`timescale 1ns/1ps
`include "pac_map.svh"
module pac_compare
  import pac_pkg::*;
#(parameter int VW = 24) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  pac_alarm_if.cmp a
);
  pac_quantity_t qty;
  logic dev;
  logic signed [VW:0] mon;
  logic signed [VW:0] cmd_x;
  logic signed [VW:0] up_x;
  logic signed [VW:0] lo_x;
  logic signed [VW:0] lo_b;
  logic signed [VW:0] hi_b;
  logic up_off_eff;
  logic below;
  logic above;

  // quantity select; one extra bit keeps command plus level from wrapping
  assign qty = pac_quantity_t'(a.type_code[`PAC_TYPE_QTY_MSB:`PAC_TYPE_QTY_LSB]);
  assign dev = (qty == PAC_Q_PV_DEV);
  assign cmd_x = {a.cmd[VW-1], a.cmd};
  assign mon = (qty == PAC_Q_SV_ABS) ? cmd_x :
               (qty == PAC_Q_MV_ABS) ? {a.mv[VW-1], a.mv} :
               {a.fb[VW-1], a.fb};
  // symmetric window borrows the lower level for the upper side
  assign up_x = a.sym ? {a.lower[VW-1], a.lower} : {a.upper[VW-1], a.upper};
  assign up_off_eff = a.sym ? a.lower_off : a.upper_off;
  assign lo_x = {a.lower[VW-1], a.lower};
  // levels and quantities share one unit, so bounds compare directly
  assign lo_b = dev ? cmd_x - lo_x : lo_x;
  assign hi_b = dev ? cmd_x + up_x : up_x;
  assign below = !a.lower_off && (mon < lo_b);
  assign above = !up_off_eff && (mon > hi_b);
  assign a.in_range = below | above;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  a_pv_abs_range: assert property ((a.type_code == 4'h0 && !a.lower_off && a.fb < a.lower) |-> a.in_range)
    else $error("feedback below lower level without alarm");
  a_dev_upper: assert property ((a.type_code == 4'h4 && !a.sym && !a.upper_off &&
    ($signed({a.fb[VW-1], a.fb}) > cmd_x + $signed({a.upper[VW-1], a.upper}))) |-> a.in_range)
    else $error("deviation above command plus upper without alarm");
  a_sv_abs_range: assert property ((a.type_code == 4'h8 && !a.upper_off && !a.sym && a.cmd > a.upper)
    |-> a.in_range)
    else $error("command above upper level without alarm");
  a_mv_abs_range: assert property ((a.type_code == 4'hC && !a.lower_off && a.mv < a.lower) |-> a.in_range)
    else $error("manipulated value below lower level without alarm");
  a_off_levels: assert property ((a.lower_off && up_off_eff) |-> !a.in_range)
    else $error("alarm raised with both levels off");
endmodule

// *** rtl/pac_hold_latch.sv ***
`timescale 1ns/1ps
`include "pac_map.svh"
module pac_hold_latch
  import pac_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  pac_alarm_if.hl a
);
  logic hold_wait;
  logic alarm_q;
  logic hold_sel;
  logic latch_sel;
  logic hold_gate;
  logic cond;
  logic next_alarm;

  assign hold_sel = a.type_code[`PAC_TYPE_HOLD_BIT];
  assign latch_sel = a.type_code[`PAC_TYPE_LATCH_BIT];
  assign hold_gate = hold_sel & hold_wait;
  assign cond = a.in_range & !hold_gate;
  // new alarm wins over a release arriving in the same cycle
  assign next_alarm = cond | (latch_sel & alarm_q & !a.release_cmd);
  assign a.alarm = alarm_q;
  assign a.hold_pending = hold_gate;

  // hold wait is armed only by power-on; only a miss while hold is selected clears it,
  // so levels can be set up after power-on without spending the hold
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_wait <= 1'b1;
      alarm_q <= 1'b0;
    end else begin
      hold_wait <= hold_wait & (a.in_range | !hold_sel);
      alarm_q <= next_alarm;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_leave_enter;
    hold_sel && !a.in_range ##1 hold_sel && a.in_range;
  endsequence
  sequence s_latched_quiet;
    latch_sel && alarm_q && !a.release_cmd;
  endsequence

  a_hold_blocks: assert property ((hold_gate && !(latch_sel && alarm_q)) |=> !alarm_q)
    else $error("alarm raised while hold still waiting");
  a_hold_rearm: assert property (s_leave_enter |=> alarm_q)
    else $error("alarm not raised after leaving and re-entering range");
  a_latch_keeps: assert property (s_latched_quiet |=> alarm_q)
    else $error("latched alarm dropped without release");
  a_release_clears: assert property ((alarm_q && a.release_cmd && !a.in_range) |=> !alarm_q)
    else $error("release did not clear alarm");
  a_plain_follow: assert property ((!latch_sel && !a.in_range) |=> !alarm_q)
    else $error("unlatched alarm stayed on out of range");
endmodule

// *** rtl/pac_map.svh ***
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH
// How it works
// - type 0 raises the alarm while feedback is below lower or above upper level
// - type 4 raises it while feedback leaves command minus lower to command plus upper
// - type 8 raises it while command value is below lower or above upper level
// - type 12 raises it while manipulated value is below lower or above upper level
// - codes decode in fours; plus one adds hold, plus two latch, plus three both
// - with hold, the alarm stays off after power-on even inside the alarm range
// - with hold, alarms arm only after the quantity leaves and re-enters the range
// - with latch, an asserted alarm stays on after the quantity leaves the range
// - a latched alarm clears only on the reset key or reset terminal command; a control write with bit 8 set also clears it here
// - upper level is OFF or a value from -999.00 to 9990.00
// - lower level is OFF or a value from -999.00 to 9990.00
// - both levels use the same physical units as the monitored quantities
// - upper-only deviation alarm uses command plus upper, lower set to full scale
// - lower-only deviation alarm uses command minus lower, upper set to full scale
// - symmetric mode uses the lower level on both sides of the command value

// register byte addresses
`define PAC_ADDR_CTRL 8'h00
`define PAC_ADDR_UPPER 8'h04
`define PAC_ADDR_LOWER 8'h08
`define PAC_ADDR_STATUS 8'h0C
`define PAC_ADDR_IRQ_STS 8'h10
`define PAC_ADDR_IRQ_MASK 8'h14

// control fields
`define PAC_CTRL_TYPE_MSB 3
`define PAC_CTRL_TYPE_LSB 0
`define PAC_CTRL_SYM_BIT 4
`define PAC_CTRL_RST_BIT 8
`define PAC_TYPE_HOLD_BIT 0
`define PAC_TYPE_LATCH_BIT 1
`define PAC_TYPE_QTY_MSB 3
`define PAC_TYPE_QTY_LSB 2

// level registers: hundredths, two's complement, off flag on top
`define PAC_LVL_W 21
`define PAC_LVL_MSB 20
`define PAC_LVL_OFF_BIT 31
`define PAC_LVL_MIN 21'h1E79C4
`define PAC_LVL_MAX 21'h0F3E58
`define PAC_LVL_RST 32'h80000000

// status and interrupt bits
`define PAC_ST_ALARM_BIT 0
`define PAC_ST_RANGE_BIT 1
`define PAC_ST_HOLD_BIT 2
`define PAC_IRQ_W 3
`define PAC_IRQ_RISE_BIT 0
`define PAC_IRQ_FALL_BIT 1
`define PAC_IRQ_REJ_BIT 2

// bus answers
`define PAC_RESP_OKAY 2'h0
`define PAC_RESP_SLVERR 2'h2
`endif

// *** rtl/pac_pkg.sv ***
package pac_pkg;
  // monitored quantity, from the upper two bits of the type code
  typedef enum logic [1:0] {
    PAC_Q_PV_ABS,
    PAC_Q_PV_DEV,
    PAC_Q_SV_ABS,
    PAC_Q_MV_ABS
  } pac_quantity_t;
endpackage
